// ### bench/operand_address_generator_tb.sv
`include "opgen_regs.svh"
`default_nettype none
module operand_address_generator_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  i_mclk = 1'b0;
  logic                  i_rst_n = 1'b0;
  logic [15:0]           gpr = 16'hABCD;
  logic [16:0]           slen = 17'h00001;
  logic [7:0]            dbyte = 8'h00;
  logic                  dpk = 1'b0;
  opgen_pkg::dec_req_t   req;
  opgen_pkg::addr_regs_t regs;
  opgen_pkg::agu_out_t   agu;
  int                    errors = 0;
  int                    n_compared = 0;
  always #4 i_mclk = ~i_mclk;
  opgen_decoder_model dec (.i_mclk(i_mclk), .o_req(req), .o_regs(regs));
  operand_address_generator uut (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_req(req), .i_regs(regs),
    .i_gpr_val(gpr), .i_str_len(slen), .i_dec_byte(dbyte), .i_dec_packed(dpk),
    .o_agu(agu)
  );
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic finish_test();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  function automatic opgen_pkg::dec_req_t mk(input opgen_pkg::amode_t m,
      input opgen_pkg::ref_kind_t k, input logic [4:0] f, input logic [15:0] d);
    mk = '0;
    mk.mode = m;
    mk.kind = k;
    {mk.use_base, mk.base_sel, mk.use_index, mk.index_sel, mk.disp_wide} = f;
    mk.disp = d;
    mk.word_op = 1'b1;
  endfunction
  task automatic op(input opgen_pkg::dec_req_t r, input logic [1:0] s, input logic [15:0] o);
    dec.send(r);
    chk("valid", 32'h1, {31'h0, agu.valid});
    chk("seg_id", {30'h0, s}, {30'h0, agu.seg_id});
    chk("offset", {16'h0, o}, {16'h0, agu.offset});
    chk("pointer", {14'h0, s, o}, agu.pointer);
  endtask
  task automatic t_segments();
    opgen_pkg::dec_req_t r;
    r = mk(opgen_pkg::AM_DIRECT, opgen_pkg::REF_FETCH, 5'h01, 16'h0010);
    r.ovr_en = 1'b1;
    op(r, `SEG_CS, 16'h0010);
    op(mk(opgen_pkg::AM_REG_IND, opgen_pkg::REF_STACK, 5'h10, 16'h0), `SEG_SS, 16'h1234);
    op(mk(opgen_pkg::AM_BASED, opgen_pkg::REF_DATA, 5'h18, 16'h00FF), `SEG_SS, 16'hFFEF);
    op(mk(opgen_pkg::AM_BASED, opgen_pkg::REF_DATA, 5'h11, 16'h0100), `SEG_DS, 16'h1334);
    op(mk(opgen_pkg::AM_REG_IND, opgen_pkg::REF_STRDST, 5'h06, 16'h0), `SEG_ES, 16'h8001);
    r = mk(opgen_pkg::AM_BASED, opgen_pkg::REF_DATA, 5'h18, 16'h00FF);
    r.ovr_en = 1'b1;
    r.ovr_seg = `SEG_ES;
    op(r, `SEG_ES, 16'hFFEF);
  endtask
  task automatic t_modes();
    op(mk(opgen_pkg::AM_DIRECT, opgen_pkg::REF_DATA, 5'h00, 16'h0080), `SEG_DS, 16'hFF80);
    chk("mem_access", 32'h1, {31'h0, agu.mem_access});
    op(mk(opgen_pkg::AM_INDEXED, opgen_pkg::REF_DATA, 5'h07, 16'h8000), `SEG_DS, 16'h0001);
    op(mk(opgen_pkg::AM_BASE_IDX, opgen_pkg::REF_DATA, 5'h14, 16'h0077), `SEG_DS, 16'h1334);
    op(mk(opgen_pkg::AM_BIX_DISP, opgen_pkg::REF_DATA, 5'h1E, 16'h0010), `SEG_SS, 16'h8001);
    op(mk(opgen_pkg::AM_REG_IND, opgen_pkg::REF_DATA, 5'h04, 16'h0), `SEG_DS, 16'h0100);
    @(posedge i_mclk);
    #1 chk("valid_drop", 32'h0, {31'h0, agu.valid});
    chk("offset_hold", 32'h0100, {16'h0, agu.offset});
  endtask
  task automatic t_reg_imm();
    opgen_pkg::dec_req_t r;
    op(mk(opgen_pkg::AM_REG, opgen_pkg::REF_DATA, 5'h00, 16'h0), `SEG_DS, 16'h0);
    chk("operand", 32'hABCD, {16'h0, agu.operand});
    chk("reg_mem", 32'h2, {30'h0, agu.reg_access, agu.mem_access});
    r = mk(opgen_pkg::AM_REG, opgen_pkg::REF_DATA, 5'h00, 16'h0);
    r.word_op = 1'b0;
    op(r, `SEG_DS, 16'h0);
    chk("byte_operand", 32'h00CD, {16'h0, agu.operand});
    r = mk(opgen_pkg::AM_IMM, opgen_pkg::REF_DATA, 5'h00, 16'h0);
    r.imm = 16'h5A5A;
    op(r, `SEG_DS, 16'h0);
    chk("imm", 32'h15A5A, {15'h0, agu.imm_operand, agu.operand});
    chk("imm_mem", 32'h0, {30'h0, agu.reg_access, agu.mem_access});
  endtask
  task automatic t_data_types();
    logic [16:0] lens [4] = '{17'h00000, 17'h00001, 17'h10000, 17'h10001};
    logic [9:0]  bcds [4] = '{10'h399, 10'h39A, 10'h009, 10'h019};
    for (int i = 0; i < 4; i++) begin
      @(posedge i_mclk);
      #1 slen = lens[i];
      {dpk, dbyte} = bcds[i][8:0];
      @(posedge i_mclk);
      #1 chk("str_len_ok", {31'h0, i[0] ^ i[1]}, {31'h0, agu.str_len_ok});
      chk("bcd_ok", {31'h0, ~i[0]}, {31'h0, agu.bcd_ok});
    end
  endtask
  initial begin
    #200us;
    errors++;
    finish_test();
  end
  initial begin
    repeat (10) @(posedge i_mclk);
    #1 chk("reset_valid", 32'h0, {31'h0, agu.valid});
    i_rst_n = 1'b1;
    t_segments();
    t_modes();
    t_reg_imm();
    t_data_types();
    finish_test();
  end
endmodule
`default_nettype wire

// ### bench/opgen_decoder_model.sv
`default_nettype none
module opgen_decoder_model (
  // Clock
  input  wire logic                  i_mclk,
  // Request and pointer registers
  output var opgen_pkg::dec_req_t    o_req,
  output var opgen_pkg::addr_regs_t  o_regs
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_req = '0;
    o_regs = {16'h1234, 16'hFFF0, 16'h0100, 16'h8001};
  end
  task automatic send(input opgen_pkg::dec_req_t r);
    opgen_pkg::dec_req_t q;
    q = r;
    q.valid = 1'b1;
    @(posedge i_mclk);
    #1 o_req = q;
    @(posedge i_mclk);
    q.valid = 1'b0;
    q.disp = ~r.disp;
    #1 o_req = q;
  endtask
endmodule
`default_nettype wire

// ### core/operand_address_generator.sv
`include "opgen_regs.svh"
`default_nettype none
module operand_address_generator (
  // Clock and reset
  input  wire logic                  i_mclk,
  input  wire logic                  i_rst_n,
  // Decoder side
  input  wire opgen_pkg::dec_req_t   i_req,
  input  wire opgen_pkg::addr_regs_t i_regs,
  input  wire logic [15:0]           i_gpr_val,
  input  wire logic [16:0]           i_str_len,
  input  wire logic [7:0]            i_dec_byte,
  input  wire logic                  i_dec_packed,
  // Bus unit side
  output var opgen_pkg::agu_out_t    o_agu
);

  function automatic logic [15:0] sext8(input logic [7:0] b);
    sext8 = {{8{b[`BYTE_SIGN]}}, b};
  endfunction

  function automatic logic digit_ok(input logic [3:0] n);
    digit_ok = (n <= `NIB_MAX);
  endfunction

  opgen_pkg::agu_out_t agu_q;
  opgen_pkg::agu_out_t agu_d;

  wire opgen_pkg::amode_t mode = i_req.mode;
  wire is_mem = (mode != opgen_pkg::AM_REG) && (mode != opgen_pkg::AM_IMM);
  wire is_fetch = (i_req.kind == opgen_pkg::REF_FETCH);

  wire [15:0] disp_ext = i_req.disp_wide ? i_req.disp : sext8(i_req.disp[7:0]);

  wire [15:0] base_val  = i_req.base_sel ? i_regs.base_pointer_reg
                                         : i_regs.general_base_reg;
  wire [15:0] index_val = i_req.index_sel ? i_regs.dest_index_reg
                                          : i_regs.src_index_reg;

  wire use_disp = (mode == opgen_pkg::AM_DIRECT) || (mode == opgen_pkg::AM_BASED) ||
                  (mode == opgen_pkg::AM_INDEXED) || (mode == opgen_pkg::AM_BIX_DISP);
  wire use_base = (mode == opgen_pkg::AM_BASED) || (mode == opgen_pkg::AM_BASE_IDX) ||
                  (mode == opgen_pkg::AM_BIX_DISP) ||
                  ((mode == opgen_pkg::AM_REG_IND) && i_req.use_base);
  wire use_idx  = (mode == opgen_pkg::AM_INDEXED) || (mode == opgen_pkg::AM_BASE_IDX) ||
                  (mode == opgen_pkg::AM_BIX_DISP) ||
                  ((mode == opgen_pkg::AM_REG_IND) && !i_req.use_base);

  wire [15:0] t_disp = use_disp ? disp_ext  : `ZERO16;
  wire [15:0] t_base = use_base ? base_val  : `ZERO16;
  wire [15:0] t_idx  = use_idx  ? index_val : `ZERO16;

  wire [17:0] sum_full = {`SUM_PAD, t_disp} + {`SUM_PAD, t_base} + {`SUM_PAD, t_idx};
  wire [15:0] offset = sum_full[15:0];

  wire bp_based = use_base && i_req.base_sel;
  wire [1:0] def_seg = is_fetch ? `SEG_CS :
                       (i_req.kind == opgen_pkg::REF_STACK) ? `SEG_SS :
                       (i_req.kind == opgen_pkg::REF_STRDST) ? `SEG_ES :
                       bp_based ? `SEG_SS : `SEG_DS;
  wire [1:0] seg_sel = (i_req.ovr_en && !is_fetch) ? i_req.ovr_seg : def_seg;

  wire [15:0] opnd = (mode == opgen_pkg::AM_IMM) ?
                     (i_req.word_op ? i_req.imm : {`ZERO8, i_req.imm[7:0]}) :
                     (i_req.word_op ? i_gpr_val : {`ZERO8, i_gpr_val[7:0]});

  wire str_ok = (i_str_len != `LEN_ZERO) && (i_str_len <= `STR_MAX_BYTES);
  wire bcd_ok = i_dec_packed ? (digit_ok(i_dec_byte[7:4]) && digit_ok(i_dec_byte[3:0]))
                             : ((i_dec_byte[7:4] == `NIB_ZERO) && digit_ok(i_dec_byte[3:0]));

  always_comb begin
    agu_d             = agu_q;
    agu_d.valid       = i_req.valid;
    agu_d.str_len_ok  = str_ok;
    agu_d.bcd_ok      = bcd_ok;
    if (i_req.valid) begin
      agu_d.mem_access  = is_mem;
      agu_d.reg_access  = (mode == opgen_pkg::AM_REG);
      agu_d.imm_operand = (mode == opgen_pkg::AM_IMM);
      agu_d.seg_id      = is_mem ? seg_sel : `SEG_DS;
      agu_d.offset      = is_mem ? offset : `ZERO16;
      agu_d.pointer     = {`PTR_PAD, agu_d.seg_id, agu_d.offset};
      agu_d.operand     = is_mem ? `ZERO16 : opnd;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      agu_q <= '0;
    end else begin
      agu_q <= agu_d;
    end
  end

  assign o_agu = agu_q;

  property p_valid_lat;
    @(posedge i_mclk) disable iff (!i_rst_n) i_req.valid |=> agu_q.valid;
  endproperty
  a_valid_lat: assert property (p_valid_lat) else $error("valid not registered");

  property p_fetch_cs;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (i_req.valid && is_mem && is_fetch) |=> (agu_q.seg_id == `SEG_CS);
  endproperty
  a_fetch_cs: assert property (p_fetch_cs) else $error("fetch not code seg");

  property p_stack_ss;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (i_req.valid && is_mem && !i_req.ovr_en && i_req.kind == opgen_pkg::REF_STACK)
      |=> (agu_q.seg_id == `SEG_SS);
  endproperty
  a_stack_ss: assert property (p_stack_ss) else $error("stack not stack seg");

  property p_strdst_es;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (i_req.valid && is_mem && !i_req.ovr_en && i_req.kind == opgen_pkg::REF_STRDST)
      |=> (agu_q.seg_id == `SEG_ES);
  endproperty
  a_strdst_es: assert property (p_strdst_es) else $error("string dest not extra");

  property p_data_ds;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (i_req.valid && is_mem && !i_req.ovr_en && i_req.kind == opgen_pkg::REF_DATA
       && !(use_base && i_req.base_sel)) |=> (agu_q.seg_id == `SEG_DS);
  endproperty
  a_data_ds: assert property (p_data_ds) else $error("data not data seg");

  property p_override;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (i_req.valid && is_mem && i_req.ovr_en && !is_fetch)
      |=> (agu_q.seg_id == $past(i_req.ovr_seg));
  endproperty
  a_override: assert property (p_override) else $error("override ignored");

  property p_direct;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (i_req.valid && mode == opgen_pkg::AM_DIRECT && !i_req.disp_wide)
      |=> (agu_q.offset == {{8{$past(i_req.disp[7])}}, $past(i_req.disp[7:0])});
  endproperty
  a_direct: assert property (p_direct) else $error("direct offset wrong");

  property p_bix;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (i_req.valid && mode == opgen_pkg::AM_BASE_IDX)
      |=> (agu_q.offset == 16'($past(base_val) + $past(index_val)));
  endproperty
  a_bix: assert property (p_bix) else $error("based indexed wrong");

  property p_imm;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (i_req.valid && mode == opgen_pkg::AM_IMM && i_req.word_op)
      |=> (!agu_q.mem_access && agu_q.operand == $past(i_req.imm));
  endproperty
  a_imm: assert property (p_imm) else $error("immediate wrong");

  property p_direct_wide;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (i_req.valid && mode == opgen_pkg::AM_DIRECT && i_req.disp_wide)
      |=> (agu_q.offset == $past(i_req.disp));
  endproperty
  a_direct_wide: assert property (p_direct_wide) else $error("wide direct wrong");

  property p_based_sext;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (i_req.valid && mode == opgen_pkg::AM_BASED && i_req.base_sel && !i_req.disp_wide)
      |=> (agu_q.offset == 16'($past(i_regs.base_pointer_reg) + sext8($past(i_req.disp[7:0]))));
  endproperty
  a_based_sext: assert property (p_based_sext) else $error("byte disp not extended");

  property p_ri_base;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (i_req.valid && mode == opgen_pkg::AM_REG_IND && i_req.use_base && !i_req.base_sel)
      |=> (agu_q.offset == $past(i_regs.general_base_reg));
  endproperty
  a_ri_base: assert property (p_ri_base) else $error("indirect base wrong");

  property p_ri_index;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (i_req.valid && mode == opgen_pkg::AM_REG_IND && !i_req.use_base && i_req.index_sel)
      |=> (agu_q.offset == $past(i_regs.dest_index_reg));
  endproperty
  a_ri_index: assert property (p_ri_index) else $error("indirect index wrong");

  property p_based;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (i_req.valid && mode == opgen_pkg::AM_BASED && !i_req.base_sel && i_req.disp_wide)
      |=> (agu_q.offset == 16'($past(i_regs.general_base_reg) + $past(i_req.disp)));
  endproperty
  a_based: assert property (p_based) else $error("based offset wrong");

  property p_indexed;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (i_req.valid && mode == opgen_pkg::AM_INDEXED && i_req.index_sel && i_req.disp_wide)
      |=> (agu_q.offset == 16'($past(i_regs.dest_index_reg) + $past(i_req.disp)));
  endproperty
  a_indexed: assert property (p_indexed) else $error("indexed offset wrong");

  property p_bix_disp;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (i_req.valid && mode == opgen_pkg::AM_BIX_DISP && i_req.base_sel && i_req.index_sel
       && !i_req.disp_wide)
      |=> (agu_q.offset == 16'($past(i_regs.base_pointer_reg) + $past(i_regs.dest_index_reg)
                                + sext8($past(i_req.disp[7:0]))));
  endproperty
  a_bix_disp: assert property (p_bix_disp) else $error("based indexed disp wrong");

  property p_bp_ss;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (i_req.valid && mode == opgen_pkg::AM_BASED && i_req.base_sel && !i_req.ovr_en
       && i_req.kind == opgen_pkg::REF_DATA) |=> (agu_q.seg_id == `SEG_SS);
  endproperty
  a_bp_ss: assert property (p_bp_ss) else $error("base pointer not stack seg");

  property p_fetch_ovr;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (i_req.valid && is_mem && is_fetch && i_req.ovr_en) |=> (agu_q.seg_id == `SEG_CS);
  endproperty
  a_fetch_ovr: assert property (p_fetch_ovr) else $error("fetch took override");

  property p_mem_flags;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (i_req.valid && is_mem) |=> (agu_q.mem_access && !agu_q.reg_access
                                   && !agu_q.imm_operand && agu_q.operand == `ZERO16);
  endproperty
  a_mem_flags: assert property (p_mem_flags) else $error("memory flags wrong");

  property p_pointer;
    @(posedge i_mclk) disable iff (!i_rst_n)
      agu_q.valid |-> (agu_q.pointer == {`PTR_PAD, agu_q.seg_id, agu_q.offset});
  endproperty
  a_pointer: assert property (p_pointer) else $error("pointer pairing wrong");

  property p_reg_mode;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (i_req.valid && mode == opgen_pkg::AM_REG && i_req.word_op)
      |=> (agu_q.reg_access && !agu_q.mem_access && agu_q.operand == $past(i_gpr_val));
  endproperty
  a_reg_mode: assert property (p_reg_mode) else $error("register operand wrong");

  property p_nonmem;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (i_req.valid && !is_mem) |=> (agu_q.seg_id == `SEG_DS && agu_q.offset == `ZERO16);
  endproperty
  a_nonmem: assert property (p_nonmem) else $error("non-memory address not cleared");

  property p_byte_zext;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (i_req.valid && mode == opgen_pkg::AM_REG && !i_req.word_op)
      |=> (agu_q.operand == {`ZERO8, $past(i_gpr_val[7:0])});
  endproperty
  a_byte_zext: assert property (p_byte_zext) else $error("byte operand wrong");

  property p_imm_flags;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (i_req.valid && mode == opgen_pkg::AM_IMM)
      |=> (agu_q.imm_operand && !agu_q.reg_access && !agu_q.mem_access);
  endproperty
  a_imm_flags: assert property (p_imm_flags) else $error("immediate flags wrong");

  property p_hold;
    @(posedge i_mclk) disable iff (!i_rst_n)
      !i_req.valid |=> ($stable(agu_q.offset) && $stable(agu_q.seg_id));
  endproperty
  a_hold: assert property (p_hold) else $error("fields changed without valid");

  property p_flags_hold;
    @(posedge i_mclk) disable iff (!i_rst_n)
      !i_req.valid |=> ($stable(agu_q.operand) && $stable(agu_q.mem_access));
  endproperty
  a_flags_hold: assert property (p_flags_hold) else $error("operand not held");

  property p_valid_drop;
    @(posedge i_mclk) disable iff (!i_rst_n)
      !i_req.valid |=> !agu_q.valid;
  endproperty
  a_valid_drop: assert property (p_valid_drop) else $error("valid not dropped");

  property p_str_len;
    @(posedge i_mclk) disable iff (!i_rst_n)
      1'h1 |=> (agu_q.str_len_ok == (($past(i_str_len) != `LEN_ZERO)
                                    && ($past(i_str_len) <= `STR_MAX_BYTES)));
  endproperty
  a_str_len: assert property (p_str_len) else $error("string length check wrong");

  property p_bcd_packed;
    @(posedge i_mclk) disable iff (!i_rst_n)
      i_dec_packed |=> (agu_q.bcd_ok == (($past(i_dec_byte[7:4]) <= `NIB_MAX)
                                        && ($past(i_dec_byte[3:0]) <= `NIB_MAX)));
  endproperty
  a_bcd_packed: assert property (p_bcd_packed) else $error("packed digit check wrong");

  property p_bcd_unpacked;
    @(posedge i_mclk) disable iff (!i_rst_n)
      !i_dec_packed |=> (agu_q.bcd_ok == (($past(i_dec_byte[7:4]) == `NIB_ZERO)
                                         && ($past(i_dec_byte[3:0]) <= `NIB_MAX)));
  endproperty
  a_bcd_unpacked: assert property (p_bcd_unpacked) else $error("unpacked digit wrong");

  c_bp_based: cover property (@(posedge i_mclk) disable iff (!i_rst_n)
    i_req.valid && bp_based && i_req.kind == opgen_pkg::REF_DATA);
  c_wrap: cover property (@(posedge i_mclk) disable iff (!i_rst_n)
    i_req.valid && is_mem && sum_full[17:16] != `SUM_PAD);
  c_override: cover property (@(posedge i_mclk) disable iff (!i_rst_n)
    i_req.valid && is_mem && i_req.ovr_en);
  c_bix_disp: cover property (@(posedge i_mclk) disable iff (!i_rst_n)
    i_req.valid && mode == opgen_pkg::AM_BIX_DISP);
  c_byte_reg: cover property (@(posedge i_mclk) disable iff (!i_rst_n)
    i_req.valid && mode == opgen_pkg::AM_REG && !i_req.word_op);

endmodule
`default_nettype wire

// ### core/opgen_pkg.sv
`default_nettype none
package opgen_pkg;
  typedef enum logic [2:0] {
    AM_REG      = 3'h0,
    AM_IMM      = 3'h1,
    AM_DIRECT   = 3'h2,
    AM_REG_IND  = 3'h3,
    AM_BASED    = 3'h4,
    AM_INDEXED  = 3'h5,
    AM_BASE_IDX = 3'h6,
    AM_BIX_DISP = 3'h7
  } amode_t;
  typedef enum logic [1:0] {
    REF_FETCH  = 2'h0,
    REF_STACK  = 2'h1,
    REF_DATA   = 2'h2,
    REF_STRDST = 2'h3
  } ref_kind_t;
  // base: 0 general base, 1 base pointer; index: 0 source, 1 dest
  typedef struct packed {
    logic        valid;
    amode_t      mode;
    ref_kind_t   kind;
    logic        use_base;
    logic        base_sel;
    logic        use_index;
    logic        index_sel;
    logic        disp_wide;
    logic [15:0] disp;
    logic        ovr_en;
    logic [1:0]  ovr_seg;
    logic        word_op;
    logic [3:0]  reg_sel;
    logic [15:0] imm;
  } dec_req_t;
  typedef struct packed {
    logic [15:0] general_base_reg;
    logic [15:0] base_pointer_reg;
    logic [15:0] src_index_reg;
    logic [15:0] dest_index_reg;
  } addr_regs_t;
  typedef struct packed {
    logic        valid;
    logic        mem_access;
    logic        reg_access;
    logic        imm_operand;
    logic [1:0]  seg_id;
    logic [15:0] offset;
    logic [31:0] pointer;
    logic [15:0] operand;
    logic        str_len_ok;
    logic        bcd_ok;
  } agu_out_t;
endpackage
`default_nettype wire

// ### core/opgen_regs.svh
`ifndef OPGEN_REGS_SVH
`define OPGEN_REGS_SVH
`define SEG_ES        2'h0
`define SEG_CS        2'h1
`define SEG_SS        2'h2
`define SEG_DS        2'h3
`define ZERO16        16'h0000
`define ZERO8         8'h00
`define BYTE_SIGN     7
`define NIB_MAX       4'h9
`define STR_MAX_BYTES 17'h10000
`define LEN_ZERO      17'h00000
`define NIB_ZERO      4'h0
`define SUM_PAD       2'h0
`define PTR_PAD       14'h0000
`endif
